// File: src/rts_top.sv
// regeneration trigger combining and progressive flow tank staging
`timescale 1ns/100ps
`default_nettype none
`include "rts_defs.svh"
module rts_top #(
  parameter int unsigned TICK_CYC = `RTS_TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration
  input wire rts_pkg::rts_cfg_s cfg,
  input wire logic [31:0] capacity,
  input wire logic [4:0] convenient_hour,
  input wire logic [15:0] trip_point,
  input wire logic [2:0] tank_total,
  input wire logic [3:0] aux_normally_on,
  input wire logic [3:0] aux_func,
  // time of day
  input wire logic day_start,
  input wire logic [2:0] weekday,
  input wire logic [4:0] hour,
  // sensors
  input wire logic meter_pulse,
  input wire logic [15:0] flow_rate,
  input wire logic resin_exhausted,
  input wire logic dp_reached,
  input wire logic aux_contact,
  // regeneration sequencer and motor
  input wire logic regen_done,
  input wire logic motor_req,
  output logic regen_start,
  output logic regen_busy,
  output logic motor_drive,
  output var rts_pkg::rts_src_s regen_cause,
  // staging, auxiliaries and volume totaliser
  output logic [2:0] tanks_online,
  output logic [5:0] tank_enable,
  output logic [3:0] aux_out,
  output logic peer_tx_valid,
  output logic [2:0] peer_tx_count,
  output logic [31:0] volume_used
);
  import rts_pkg::*;

  function automatic logic [2:0] clamp_tanks(input logic [2:0] n);
    if (n < 3'(`RTS_MIN_TANKS)) return 3'(`RTS_MIN_TANKS);
    if (n > 3'(`RTS_MAX_TANKS)) return 3'(`RTS_MAX_TANKS);
    return n;
  endfunction : clamp_tanks

  function automatic logic [6:0] clamp_days(input logic [6:0] d);
    if (d < 7'(`RTS_DAYS_MIN)) return 7'(`RTS_DAYS_MIN);
    if (d > 7'(`RTS_DAYS_MAX)) return 7'(`RTS_DAYS_MAX);
    return d;
  endfunction : clamp_days

  // true on the selected weekdays; a weekday code of 7 never matches
  function automatic logic day_selected(input logic [6:0] mask, input logic [2:0] wd);
    if (wd > 3'd6) return 1'b0;
    return mask[wd];
  endfunction : day_selected

  // flow at or above the given multiple of the trip point
  function automatic logic flow_reaches(input logic [15:0] flow, input logic [15:0] trip,
                                        input logic [2:0] mult);
    return 32'(flow) >= 32'(trip) * 32'(mult);
  endfunction : flow_reaches

  // flow under the drop-out share of the given multiple of the trip point
  function automatic logic flow_under_drop(input logic [15:0] flow, input logic [15:0] trip,
                                           input logic [2:0] mult);
    return 32'(flow) * 32'd100 < 32'(trip) * 32'(mult) * 32'(`RTS_DROP_PCT);
  endfunction : flow_under_drop

  rts_state_e state;
  rts_src_s src;
  rts_src_s latched;
  logic [31:0] tick_cnt;
  logic tick;
  logic [6:0] day_cnt;
  logic vol_full;
  logic [9:0] aux_sec;
  logic aux_armed;
  logic [2:0] next_tanks;
  logic [5:0] drop_sec;
  logic [5:0] next_enable;

  // one second tick
  // the tick length is a parameter so that a short second speeds up simulation
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(TICK_CYC - 1)) begin
      tick_cnt <= 32'h0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // day interval counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      day_cnt <= 7'h0;
    end else if (state == RTS_RUN) begin
      day_cnt <= 7'h0;
    end else if (day_start && day_cnt < 7'(`RTS_DAYS_MAX)) begin
      day_cnt <= day_cnt + 7'h1;
    end
  end

  // volume totaliser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      volume_used <= 32'h0;
    end else if (regen_start) begin
      volume_used <= 32'h0;
    end else if (meter_pulse && volume_used != 32'hffffffff) begin
      volume_used <= volume_used + 32'h1;
    end
  end
  // a full totaliser stays pending until the start pulse clears it
  assign vol_full = cfg.use_volume && capacity != 32'h0 && volume_used >= capacity;

  // aux input persistence; contact must reopen before it can fire again
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aux_sec <= 10'h0;
      aux_armed <= 1'b1;
    end else if (!aux_contact) begin
      aux_sec <= 10'h0;
      aux_armed <= 1'b1;
    end else if (state == RTS_RUN) begin
      aux_armed <= 1'b0;
    end else if (tick && aux_sec < 10'(`RTS_AUX_SEC_MAX)) begin
      aux_sec <= aux_sec + 10'h1;
    end
  end

  always_comb begin
    src.timeclock = (cfg.use_interval && day_start &&
                     day_cnt + 7'h1 >= clamp_days(cfg.interval_days)) ||
                    (cfg.use_weekday && day_start &&
                     day_selected(cfg.weekday_mask, weekday));
    src.volume = vol_full && (cfg.immediate || hour == convenient_hour);
    src.sensor = cfg.use_sensor && resin_exhausted;
    src.dp = cfg.use_dp && dp_reached;
    src.aux_in = cfg.use_aux_in && aux_contact && aux_armed &&
                 aux_sec >= cfg.aux_in_sec;
  end

  // request state: idle, pending for one cycle, running until done
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= RTS_IDLE;
    end else begin
      case (state)
        RTS_IDLE: begin
          if (src != '0) state <= RTS_PEND;
        end
        RTS_PEND: begin
          state <= RTS_RUN;
        end
        RTS_RUN: begin
          if (regen_done) state <= RTS_IDLE;
        end
        default: begin
          state <= RTS_IDLE;
        end
      endcase
    end
  end

  // triggers seen while idle, merged into one request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      latched <= '0;
    end else if (state == RTS_IDLE) begin
      latched <= src;
    end
  end

  // one start pulse per request
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regen_start <= 1'b0;
    end else begin
      regen_start <= (state == RTS_PEND);
    end
  end

  // busy from the start until the sequencer reports done
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regen_busy <= 1'b0;
    end else if (state == RTS_PEND) begin
      regen_busy <= 1'b1;
    end else if (state == RTS_RUN && regen_done) begin
      regen_busy <= 1'b0;
    end
  end

  // causes reported with the start pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regen_cause <= '0;
    end else if (state == RTS_PEND) begin
      regen_cause <= latched | src;
    end
  end

  // target tank count from flow against multiples of the trip point
  always_comb begin
    next_tanks = 3'd1;
    for (int k = 1; k < `RTS_MAX_TANKS; k++) begin
      if (trip_point != 16'h0 && k < int'(clamp_tanks(tank_total)) &&
          flow_reaches(flow_rate, trip_point, 3'(k)))
        next_tanks = 3'(k + 1);
    end
  end

  // staging evaluated once per second; drop-out after 60 s below 95%
  // only one tank leaves per drop, so a sudden fall in flow sheds them a minute apart
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tanks_online <= 3'd1;
      drop_sec <= 6'h0;
    end else if (tick) begin
      if (next_tanks > tanks_online) begin
        tanks_online <= next_tanks;
        drop_sec <= 6'h0;
      end else if (tanks_online > 3'd1 &&
                   flow_under_drop(flow_rate, trip_point, tanks_online - 3'd1)) begin
        if (drop_sec >= 6'(`RTS_DROP_SEC - 1)) begin
          tanks_online <= tanks_online - 3'd1;
          drop_sec <= 6'h0;
        end else begin
          drop_sec <= drop_sec + 6'h1;
        end
      end else begin
        drop_sec <= 6'h0;
      end
    end
  end

  // tank enables and peer update only on count change
  genvar g;
  generate
    for (g = 0; g < `RTS_MAX_TANKS; g++) begin : g_en
      assign next_enable[g] = (3'(g) < tanks_online);
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tank_enable <= 6'h01;
    end else if (next_enable != tank_enable) begin
      tank_enable <= next_enable;
    end
  end

  // peer link: one update per count change, carrying the new count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      peer_tx_valid <= 1'b0;
      peer_tx_count <= 3'd1;
    end else begin
      peer_tx_valid <= (next_enable != tank_enable);
      if (next_enable != tank_enable) begin
        peer_tx_count <= tanks_online;
      end
    end
  end

  // motor drive follows the sequencer request only while regenerating
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      motor_drive <= 1'b0;
    end else begin
      motor_drive <= regen_busy && motor_req;
    end
  end

  // programmable auxiliaries; aux 4 doubles as the blocking valve
  genvar a;
  generate
    for (a = 0; a < `RTS_N_AUX; a++) begin : g_aux
      logic active;
      if (a == `RTS_AUX_BLOCK) begin : g_block
        assign active = !tank_enable[0] || regen_busy;
      end else begin : g_prog
        assign active = aux_func[a] && regen_busy;
      end
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          aux_out[a] <= 1'b0;
        end else begin
          aux_out[a] <= aux_normally_on[a] ^ active;
        end
      end
    end
  endgenerate
endmodule : rts_top
`default_nettype wire

// File: src/rts_defs.svh
// constants for the regeneration trigger and tank staging block
`ifndef RTS_DEFS_SVH
`define RTS_DEFS_SVH
`define RTS_CLK_HZ 50000000
`define RTS_TICK_CYC (`RTS_CLK_HZ)
`define RTS_MAX_TANKS 6
`define RTS_MIN_TANKS 2
`define RTS_DROP_PCT 95
`define RTS_DROP_SEC 60
`define RTS_DAYS_MIN 1
`define RTS_DAYS_MAX 99
`define RTS_AUX_SEC_MAX 999
`define RTS_AUX_SEC_DEF 6
`define RTS_SEC_PER_DAY 86400
`define RTS_N_AUX 4
`define RTS_AUX_BLOCK 3
`endif

// File: src/rts_pkg.sv
// types for the regeneration trigger and tank staging block
package rts_pkg;
  typedef enum logic [1:0] {
    RTS_IDLE = 2'b00,
    RTS_PEND = 2'b01,
    RTS_RUN = 2'b11
  } rts_state_e;
  typedef struct packed {
    logic [6:0] interval_days;
    logic [6:0] weekday_mask;
    logic use_interval;
    logic use_weekday;
    logic use_volume;
    logic immediate;
    logic use_sensor;
    logic use_dp;
    logic use_aux_in;
    logic [9:0] aux_in_sec;
  } rts_cfg_s;
  typedef struct packed {
    logic timeclock;
    logic volume;
    logic sensor;
    logic dp;
    logic aux_in;
  } rts_src_s;
endpackage : rts_pkg

// File: testbench/rts_far.sv
// far-side model: sensors, aux contact and regeneration sequencer
`timescale 1ns/100ps
`default_nettype none
module rts_far (
  // clock, block output and bench requests
  input wire logic sys_clk,
  input wire logic regen_start,
  input wire logic [2:0] req,
  input wire logic [7:0] lag,
  // far-side signals
  output logic regen_done,
  output logic resin_exhausted,
  output logic dp_reached,
  output logic aux_contact
);
  int n = -1;
  initial {regen_done, resin_exhausted, dp_reached, aux_contact} = '0;
  always @(posedge sys_clk) begin
    regen_done <= (n == 0);
    if (n >= 0) n <= n - 1;
    if (regen_start) n <= lag;
    // a fresh bed and an opened contact once regeneration is under way
    if (regen_start) {resin_exhausted, dp_reached, aux_contact} <= 3'h0;
    else {resin_exhausted, dp_reached, aux_contact} <= {resin_exhausted, dp_reached, aux_contact} | req;
  end
endmodule : rts_far
`default_nettype wire

// File: testbench/rts_chk.sv
// port assertions for the trigger and staging block
`timescale 1ns/100ps
`default_nettype none
module rts_chk #(
  parameter int unsigned TICK_CYC = 10
) (
  // watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire rts_pkg::rts_cfg_s cfg,
  input wire logic resin_exhausted,
  input wire logic dp_reached,
  input wire logic regen_done,
  input wire logic regen_start,
  input wire logic regen_busy,
  input wire rts_pkg::rts_src_s regen_cause,
  input wire logic [2:0] tanks_online,
  input wire logic [5:0] tank_enable,
  input wire logic peer_tx_valid,
  input wire logic [2:0] peer_tx_count
);
  import rts_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence run_s; regen_busy ##1 regen_busy; endsequence
  sequence moved_s; $past(rst_n) && $changed(tanks_online); endsequence
  start_busy_a: assert property (regen_start |-> run_s)
    else $error("busy not raised with start");
  busy_hold_a: assert property (regen_busy && !regen_done |=> regen_busy)
    else $error("busy dropped early");
  busy_end_a: assert property (regen_busy && regen_done |=> !regen_busy)
    else $error("busy kept after done");
  single_start_a: assert property (regen_busy |=> !regen_start)
    else $error("second start in one request");
  cause_any_a: assert property (regen_start |-> regen_cause != '0)
    else $error("start without cause");
  sensor_cause_a: assert property (regen_start && regen_cause.sensor |->
    cfg.use_sensor && ($past(resin_exhausted) || $past(resin_exhausted, 2)))
    else $error("sensor cause wrong");
  dp_cause_a: assert property (regen_start && regen_cause.dp |->
    cfg.use_dp && ($past(dp_reached) || $past(dp_reached, 2)))
    else $error("pressure cause wrong");
  base_tank_a: assert property (tank_enable[0] && tanks_online != 0 && tanks_online <= 3'd6)
    else $error("tank count out of range");
  stage_out_a: assert property (moved_s |=> peer_tx_valid &&
    $countones(tank_enable) == peer_tx_count) else $error("staging outputs lag");
  drop_one_a: assert property ($past(rst_n) && tanks_online < $past(tanks_online) |->
    tanks_online == $past(tanks_online) - 3'd1) else $error("more than one tank dropped");
endmodule : rts_chk
bind rts_top rts_chk #(.TICK_CYC(TICK_CYC)) chk (.*);
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the trigger and staging block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
  import rts_pkg::*;
  logic sys_clk = 0, rst_n = 0, day_start = 0, meter_pulse = 0, motor_req = 0;
  logic regen_done, aux_contact, resin_exhausted, dp_reached;
  logic regen_start, regen_busy, motor_drive, peer_tx_valid;
  logic [2:0] weekday = 0, tank_total = 4, req = 0, tanks_online, peer_tx_count, te;
  logic [4:0] hour = 0, convenient_hour = 5;
  logic [15:0] trip_point = 50, flow_rate = 0;
  logic [3:0] aux_normally_on = 0, aux_func = 0, aux_out;
  logic [31:0] capacity = 0, volume_used;
  logic [7:0] lag = 0;
  logic [5:0] tank_enable;
  rts_cfg_s cfg = '0;
  rts_src_s regen_cause, ce, cq[$];
  logic [2:0] tq[$];
  int miscompares = 0, total_checks = 0, w, t;
  always #10 sys_clk = ~sys_clk;
  rts_top #(.TICK_CYC(10)) uut (.*);
  rts_far far (.*);
  task automatic tick(int n); repeat (n) @(negedge sys_clk); endtask : tick
  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic pulse(int n, ref logic s);
    repeat (n) begin
      s = 1;
      tick(1);
      s = 0;
      tick(1);
    end
  endtask : pulse
  task automatic poke(logic [2:0] r);
    req = r;
    tick(1);
    req = 3'h0;
    tick(1);
  endtask : poke
  task automatic fin;
    int i;
    logic [3:0] ax;
    motor_req = 1'($urandom);
    aux_normally_on = 4'($urandom);
    aux_func = 4'($urandom);
    ax = aux_normally_on ^ {1'b1, aux_func[2:0]};
    for (i = 0; i < 100 && regen_busy !== 1'b1; i++) tick(1);
    tick(1);
    `CHK("motor_drive", motor_req, motor_drive)
    `CHK("aux_out", ax, aux_out)
    for (i = 0; i < 900 && (cq.size() || regen_busy !== 1'b0); i++) tick(1);
    `CHK("regen_busy", 0, cq.size() + (regen_busy !== 1'b0))
    tick(5);
    `CHK("aux_out", aux_normally_on, aux_out)
    `CHK("motor_drive", 1'b0, motor_drive)
  endtask : fin
  task automatic stage(int f, int n, int lo);
    int i;
    flow_rate = 16'(f);
    if (n > 0) tq.push_back(3'(n));
    for (i = 0; i < lo + 200 && tq.size(); i++) tick(1);
    `CHK("stage_time", 1'b1, i >= lo && tq.size() == 0)
    tick(20);
  endtask : stage
  always @(negedge sys_clk) begin
    if (rst_n && regen_start) begin
      ce = cq.size() ? cq.pop_front() : 5'h1f;
      `CHK("regen_cause", ce, regen_cause)
    end
    if (rst_n && peer_tx_valid) begin
      te = tq.size() ? tq.pop_front() : 3'h7;
      `CHK("peer_tx_count", te, peer_tx_count)
    end
  end
  initial begin
    void'($urandom(32'h72848a84));
    t = 20 + $urandom % 80;
    trip_point = 16'(t);
    lag = 8'($urandom % 40);
    aux_normally_on = 4'($urandom);
    aux_func = 4'($urandom);
    w = $urandom % 7;
    tick(10);
    rst_n = 1;
    tick(2);
    cfg.use_sensor = 1;
    cq.push_back(5'h04);
    poke(3'h4);
    fin;
    cfg.use_dp = 1;
    cq.push_back(5'h06);
    poke(3'h6);
    fin;
    cfg.use_aux_in = 1;
    cfg.aux_in_sec = 10'($urandom % 5);
    cq.push_back(5'h01);
    poke(3'h1);
    fin;
    {cfg.use_volume, cfg.immediate, capacity} = {2'h3, 32'h3};
    pulse(2, meter_pulse);
    `CHK("volume_used", 32'h2, volume_used)
    cq.push_back(5'h08);
    pulse(1, meter_pulse);
    fin;
    cfg.immediate = 0;
    convenient_hour = 5'(1 + $urandom % 23);
    pulse(3, meter_pulse);
    tick(20);
    cq.push_back(5'h08);
    hour = convenient_hour;
    fin;
    {cfg.use_volume, cfg.use_weekday, cfg.weekday_mask} = {2'h1, 7'(1 << w)};
    weekday = 3'((w + 1) % 7);
    pulse(1, day_start);
    tick(10);
    weekday = 3'(w);
    cq.push_back(5'h10);
    pulse(1, day_start);
    fin;
    {cfg.use_weekday, cfg.use_interval, cfg.interval_days} = {2'h1, 7'($urandom % 2)};
    cq.push_back(5'h10);
    pulse(1, day_start);
    fin;
    cfg = '0;
    tank_total = 3'($urandom);
    w = tank_total < 2 ? 2 : (tank_total > 6 ? 6 : tank_total);
    for (int k = 1; k <= 5; k++) stage(k * t, k < w ? k + 1 : 0, 0);
    for (int k = w - 1; k >= 1; k--) stage(0, k, 560);
    stop_test;
  end
  initial begin
    #400us;
    miscompares++;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
